// file: hdl/pcr_pkg.sv
// shared constants and carrier types for the counter and module register block
package pcr_pkg;
   localparam int unsigned PCR_CHANNELS = 6;
   localparam int unsigned PCR_BYTE_W   = 8;
   localparam int unsigned PCR_WORD_W   = 16;

   // register offsets on the special-function-register bus
   localparam logic [7:0] PCR_ADDR_COUNTER_LOWER = 8'hf9;
   localparam logic [7:0] PCR_ADDR_COUNTER_UPPER = 8'hfa;
   localparam logic [7:0] PCR_ADDR_MATCH_LOW  [PCR_CHANNELS] = '{8'hfb, 8'he9, 8'heb, 8'hed, 8'hfd, 8'hce};
   localparam logic [7:0] PCR_ADDR_MATCH_HIGH [PCR_CHANNELS] = '{8'hfc, 8'hea, 8'hec, 8'hee, 8'hfe, 8'hcf};

   // reset values and the count increment
   localparam logic [7:0]  PCR_BYTE_RESET = 8'h00;
   localparam logic [15:0] PCR_WORD_RESET = 16'h0000;
   localparam logic [15:0] PCR_COUNT_STEP = 16'h0001;

   // one access from the processor core, same clock
   typedef struct packed {
      logic [7:0] addr;
      logic [7:0] wdata;
      logic       wr;
      logic       rd;
   } pcr_sfr_req_t;

   // what one capture/compare module holds
   typedef struct packed {
      logic [15:0] match_value;
      logic [15:0] reload_value;
      logic        comparator_enable;
   } pcr_chan_t;
endpackage : pcr_pkg

// file: hdl/pcr_chan.sv
// one capture/compare module: match value, auto-reload value and comparator enable
`timescale 1ns/100ps
module pcr_chan
   import pcr_pkg::*;
(
   input  wire logic                    clock,
   input  wire logic                    nrst,
   input  wire logic                    wr_low,
   input  wire logic                    wr_high,
   input  wire logic                    auto_reload_select,
   input  wire logic [PCR_BYTE_W-1:0]   wdata,
   input  wire logic                    enable_wr,
   input  wire logic                    enable_wdata,
   output pcr_pkg::pcr_chan_t           state
);
   import pcr_pkg::*;

   pcr_chan_t next_state;

   ////////////////////////////////////////////////////////////////////////////
   always_comb begin
      next_state = state;
      // mode-register write first so a same-cycle byte write has the last word
      if (enable_wr) begin
         next_state.comparator_enable = enable_wdata;
      end
      if (wr_low) begin
         if (auto_reload_select) begin
            next_state.reload_value[7:0] = wdata;
         end else begin
            next_state.match_value[7:0] = wdata;
         end
         next_state.comparator_enable = 1'b0;
      end
      if (wr_high) begin
         if (auto_reload_select) begin
            next_state.reload_value[15:8] = wdata;
         end else begin
            next_state.match_value[15:8] = wdata;
         end
         next_state.comparator_enable = 1'b1;
      end
   end

   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         state.match_value       <= PCR_WORD_RESET;
         state.reload_value      <= PCR_WORD_RESET;
         state.comparator_enable <= 1'b0;
      end else begin
         state <= next_state;
      end
   end
endmodule : pcr_chan

// file: hdl/pcr_regs.sv
// counter and capture/compare module register access for the counter array
`timescale 1ns/100ps
module pcr_regs
   import pcr_pkg::*;
#(
   parameter int unsigned CHANNELS = PCR_CHANNELS
)(
   input  wire logic                    clock,
   input  wire logic                    nrst,
   input  pcr_pkg::pcr_sfr_req_t        sfr_req,
   input  wire logic                    watchdog_mode_enable,
   input  wire logic                    auto_reload_select,
   input  wire logic                    count_step,
   input  wire logic [CHANNELS-1:0]     enable_wr,
   input  wire logic [CHANNELS-1:0]     enable_wdata,
   output logic [7:0]                   sfr_rdata,
   output logic [15:0]                  array_counter,
   output pcr_pkg::pcr_chan_t           chan [CHANNELS]
);
   import pcr_pkg::*;

   logic [7:0]          snapshot;
   logic [7:0]          next_snapshot;
   logic [15:0]         next_array_counter;
   logic [7:0]          next_sfr_rdata;
   logic [CHANNELS-1:0] hit_low;
   logic [CHANNELS-1:0] hit_high;
   logic                hit_lower;
   logic                hit_upper;

   ////////////////////////////////////////////////////////////////////////////
   // address decode
   assign hit_lower = sfr_req.addr == PCR_ADDR_COUNTER_LOWER;
   assign hit_upper = sfr_req.addr == PCR_ADDR_COUNTER_UPPER;

   always_comb begin
      for (int i = 0; i < CHANNELS; i++) begin
         hit_low[i]  = sfr_req.addr == PCR_ADDR_MATCH_LOW[i];
         hit_high[i] = sfr_req.addr == PCR_ADDR_MATCH_HIGH[i];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // array counter and snapshot; a software write beats a count step
   always_comb begin
      next_array_counter = array_counter;
      next_snapshot      = snapshot;
      if (count_step) begin
         next_array_counter = array_counter + PCR_COUNT_STEP;
      end
      // the watchdog owns the counter while its mode is on
      if (sfr_req.wr && !watchdog_mode_enable) begin
         if (hit_lower) begin
            next_array_counter[7:0] = sfr_req.wdata;
         end
         if (hit_upper) begin
            next_array_counter[15:8] = sfr_req.wdata;
         end
      end
      // the live count is caught before any step this cycle, so the pair is coherent
      if (sfr_req.rd && hit_lower) begin
         next_snapshot = array_counter[15:8];
      end
   end

   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         array_counter <= PCR_WORD_RESET;
         snapshot      <= PCR_BYTE_RESET;
      end else begin
         array_counter <= next_array_counter;
         snapshot      <= next_snapshot;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // capture/compare modules; comparator_enable feeds the comparators outside
   for (genvar g = 0; g < CHANNELS; g++) begin : g_chan
      pcr_chan u_chan (
         .clock              (clock),
         .nrst               (nrst),
         .wr_low             (sfr_req.wr && hit_low[g]),
         .wr_high            (sfr_req.wr && hit_high[g]),
         .auto_reload_select (auto_reload_select),
         .wdata              (sfr_req.wdata),
         .enable_wr          (enable_wr[g]),
         .enable_wdata       (enable_wdata[g]),
         .state              (chan[g])
      );
   end

   ////////////////////////////////////////////////////////////////////////////
   // read data, registered; unmapped addresses read zero
   always_comb begin
      next_sfr_rdata = sfr_rdata;
      if (sfr_req.rd) begin
         next_sfr_rdata = PCR_BYTE_RESET;
         if (hit_lower) begin
            next_sfr_rdata = array_counter[7:0];
         end
         if (hit_upper) begin
            next_sfr_rdata = snapshot;
         end
         for (int i = 0; i < CHANNELS; i++) begin
            if (hit_low[i]) begin
               next_sfr_rdata = auto_reload_select ? chan[i].reload_value[7:0]
                                                   : chan[i].match_value[7:0];
            end
            if (hit_high[i]) begin
               next_sfr_rdata = auto_reload_select ? chan[i].reload_value[15:8]
                                                   : chan[i].match_value[15:8];
            end
         end
      end
   end

   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         sfr_rdata <= PCR_BYTE_RESET;
      end else begin
         sfr_rdata <= next_sfr_rdata;
      end
   end
endmodule : pcr_regs

// file: tb/pcr_regs_sva.sv
// assertion checker for the counter and module register block
`timescale 1ns/100ps
module pcr_regs_sva
   import pcr_pkg::*;
#(
   parameter int unsigned CHANNELS = PCR_CHANNELS
)(
   input  wire logic                clock,
   input  wire logic                nrst,
   input  pcr_pkg::pcr_sfr_req_t    sfr_req,
   input  wire logic                watchdog_mode_enable,
   input  wire logic                auto_reload_select,
   input  wire logic                count_step,
   input  wire logic [CHANNELS-1:0] enable_wr,
   input  wire logic [CHANNELS-1:0] enable_wdata,
   input  wire logic [7:0]          sfr_rdata,
   input  wire logic [15:0]         array_counter,
   input  pcr_pkg::pcr_chan_t       chan [CHANNELS]
);
   import pcr_pkg::*;
   default clocking cb @(posedge clock); endclocking
   default disable iff (!nrst);
   logic [7:0] snap;
   logic [7:0] next_snap;
   wire        w_lo = sfr_req.wr && sfr_req.addr == 8'hfb;
   wire        w_hi = sfr_req.wr && sfr_req.addr == 8'hfc;
   wire        w_up = sfr_req.wr && sfr_req.addr == 8'hfa;
   wire        r_lo = sfr_req.rd && sfr_req.addr == 8'hf9;
   ////////////////////////////////////////////////////////////////
   always_comb begin
      next_snap = snap;
      if (r_lo) begin
         next_snap = array_counter[15:8];
      end
   end
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         snap <= 8'h00;
      end else begin
         snap <= next_snap;
      end
   end
   ////////////////////////////////////////////////////////////////
   chk_low_clears_en: assert property (w_lo |=> !chan[0].comparator_enable)
      else $error("low write kept enable");
   chk_high_sets_en: assert property (w_hi |=> chan[0].comparator_enable)
      else $error("high write left enable clear");
   chk_low_stores: assert property (w_lo && !auto_reload_select
      |=> chan[0].match_value[7:0] == $past(sfr_req.wdata)) else $error("low byte not stored");
   chk_high_stores: assert property (w_hi && !auto_reload_select
      |=> chan[0].match_value[15:8] == $past(sfr_req.wdata)) else $error("high byte not stored");
   chk_reload_steer: assert property (w_lo && auto_reload_select
      |=> chan[0].reload_value[7:0] == $past(sfr_req.wdata) && $stable(chan[0].match_value))
      else $error("reload byte misrouted");
   chk_lower_read: assert property (r_lo |=> sfr_rdata == $past(array_counter[7:0]))
      else $error("lower byte read wrong");
   chk_snap_read: assert property (sfr_req.rd && sfr_req.addr == 8'hfa |=> sfr_rdata == $past(snap))
      else $error("upper read not snapshot");
   chk_wdog_lock: assert property (w_up && watchdog_mode_enable && !count_step
      |=> $stable(array_counter[15:8])) else $error("locked upper byte changed");
   chk_upper_write: assert property (w_up && !watchdog_mode_enable
      |=> array_counter[15:8] == $past(sfr_req.wdata)) else $error("upper byte not written");
endmodule : pcr_regs_sva

bind pcr_regs pcr_regs_sva #(.CHANNELS(CHANNELS)) u_sva (.clock(clock), .nrst(nrst), .sfr_req(sfr_req),
   .watchdog_mode_enable(watchdog_mode_enable), .auto_reload_select(auto_reload_select),
   .count_step(count_step), .enable_wr(enable_wr), .enable_wdata(enable_wdata),
   .sfr_rdata(sfr_rdata), .array_counter(array_counter), .chan(chan));

// file: tb/tb.sv
// self-checking bench for the counter and module register block
`timescale 1ns/100ps
module tb;
   import pcr_pkg::*;
   logic         clock, nrst, wde, ars, step;
   pcr_sfr_req_t req;
   logic [5:0]   en_wr, en_wd;
   logic [7:0]   rdata, v;
   logic [15:0]  cnt;
   logic [3:0]   k;
   pcr_chan_t    chan [PCR_CHANNELS];
   int           fail_count = 0;
   int           checked = 0;
   pcr_regs dut (.clock(clock), .nrst(nrst), .sfr_req(req), .watchdog_mode_enable(wde),
      .auto_reload_select(ars), .count_step(step), .enable_wr(en_wr), .enable_wdata(en_wd),
      .sfr_rdata(rdata), .array_counter(cnt), .chan(chan));
   ////////////////////////////////////////////////////////////////
   task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
      checked++;
      if (got !== exp) begin
         fail_count++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : cmp
   // idle cycle after each access so strobes never retoggle in one step
   task automatic acc(input logic [7:0] a, input logic [7:0] d, input logic w);
      req = '{a, d, w, !w};
      @(posedge clock);
      #1 req = '0;
      v = rdata;
      @(posedge clock);
      #1;
   endtask : acc
   task automatic rdv(input logic [7:0] a, input logic [7:0] exp);
      acc(a, 8'h00, 1'b0);
      cmp(v, exp);
   endtask : rdv
   task automatic wrap_up;
      $display("comparisons %0d mismatches %0d", checked, fail_count);
      if (fail_count == 0 && checked > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask : wrap_up
   ////////////////////////////////////////////////////////////////
   initial begin
      clock = 1'b0;
      forever #4 clock = ~clock;
   end
   initial begin
      #500000;
      fail_count++;
      wrap_up;
   end
   initial begin
      nrst = 1'b0;
      req = '0;
      {wde, ars, step, en_wr, en_wd} = '0;
      repeat (16) @(posedge clock);
      #1 nrst = 1'b1;
      for (int i = 0; i < 6; i++) begin
         rdv(PCR_ADDR_MATCH_LOW[i], 8'h00);
         rdv(PCR_ADDR_MATCH_HIGH[i], 8'h00);
      end
      rdv(PCR_ADDR_COUNTER_UPPER, 8'h00);
      acc(PCR_ADDR_COUNTER_UPPER, 8'h12, 1'b1);
      acc(PCR_ADDR_COUNTER_LOWER, 8'hff, 1'b1);
      cmp(cnt, 16'h12ff);
      rdv(PCR_ADDR_COUNTER_UPPER, 8'h00);
      step = 1'b1;
      @(posedge clock);
      #1 step = 1'b0;
      rdv(PCR_ADDR_COUNTER_LOWER, 8'h00);
      rdv(PCR_ADDR_COUNTER_UPPER, 8'h13);
      wde = 1'b1;
      acc(PCR_ADDR_COUNTER_UPPER, 8'haa, 1'b1);
      acc(PCR_ADDR_COUNTER_LOWER, 8'h55, 1'b1);
      cmp(cnt, 16'h1300);
      wde = 1'b0;
      for (int i = 0; i < 6; i++) begin
         k = i[3:0];
         en_wd = '1;
         en_wr[i] = 1'b1;
         @(posedge clock);
         #1 en_wr = '0;
         acc(PCR_ADDR_MATCH_LOW[i], {4'h1, k}, 1'b1);
         cmp(chan[i].comparator_enable, 16'h0000);
         acc(PCR_ADDR_MATCH_HIGH[i], {4'h2, k}, 1'b1);
         cmp(chan[i].comparator_enable, 16'h0001);
         ars = 1'b1;
         acc(PCR_ADDR_MATCH_LOW[i], {4'h3, k}, 1'b1);
         acc(PCR_ADDR_MATCH_HIGH[i], {4'h4, k}, 1'b1);
         cmp(chan[i].reload_value, {4'h4, k, 4'h3, k});
         cmp(chan[i].match_value, {4'h2, k, 4'h1, k});
         rdv(PCR_ADDR_MATCH_LOW[i], {4'h3, k});
         ars = 1'b0;
         rdv(PCR_ADDR_MATCH_HIGH[i], {4'h2, k});
      end
      // unmapped address reads as zero
      rdv(8'h80, 8'h00);
      wrap_up;
   end
endmodule : tb
